// File: shared/io_led_regs.svh
`ifndef IO_LED_REGS_SVH
`define IO_LED_REGS_SVH
// What this block does
// - Reset makes all three lines disabled inputs
// - Line functions selected by software registers
// - Disabled input line level is ignored
// - General input shows line level in status
// - Trigger input edge with selectable polarity
// - General output drives per-line software bit
// - Frame end pulse after delay, width, polarity
// - Exposure active level follows actual exposure
// - Output pulse width is software programmable
// - Lamp per link: off unconnected, orange booting
// - External power, no link: slow red blink
// - Linking: green/orange fast, or orange fast
// - Connected idle: solid green
// - Incompatible on cable power: red/green slow
// - Incompatible on external power: red/orange slow
// - Waiting for trigger: slow orange flash
// - Transferring: fast green flash
// - Transfer error red 500 ms; system error fast
`define OFS_IN_FUNC 8'h00
`define OFS_OUT_FUNC 8'h04
`define OFS_POL 8'h08
`define OFS_USR_OUT 8'h0C
`define OFS_DELAY 8'h10
`define OFS_WIDTH 8'h14
`define OFS_LINE_STAT 8'h18
`define OFS_IRQ_STAT 8'h1C
`define OFS_IRQ_CLR 8'h20
`define OFS_IRQ_EN 8'h24
`define OFS_DIR 8'h28
`define RST_WIDTH 32'h0000_000A
`define ERR_SHOW_MS 500
`define CLK_HZ 10000000
`define ERR_SHOW_CYC ((`ERR_SHOW_MS * (`CLK_HZ / 1000)))
`endif

// File: shared/io_led_pkg.sv
package io_led_pkg;
  typedef enum logic [1:0] {
    IN_OFF = 2'h0, IN_LEVEL = 2'h1, IN_TRIG = 2'h2
  } in_func_t;
  typedef enum logic [1:0] {
    OUT_OFF = 2'h0, OUT_USER = 2'h1, OUT_FEND = 2'h2, OUT_EXPO = 2'h3
  } out_func_t;
  typedef struct packed {
    logic booting;
    logic ext_power;
    logic cable_power;
    logic linking;
    logic connected;
    logic incompatible;
    logic wait_trig;
    logic transferring;
    logic xfer_error;
    logic sys_error;
  } link_stat_t;
  typedef struct packed {
    logic red;
    logic green;
  } lamp_t;
endpackage

// File: rtl/io_led_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
`include "io_led_regs.svh"
module io_led_ctrl import io_led_pkg::*; #(
  parameter int NLINK = 4,
  parameter int SLOW_CYC = 5000000,
  parameter int FAST_CYC = 1000000,
  parameter int MIN_SHOW_CYC = 10000000,
  parameter int ERR_CYC = `ERR_SHOW_CYC,
  parameter bit XFER_ERR_FIRST = 1'b0
) (
  input wire logic CLK_I,
  input wire logic SRST_I,
  input wire logic [7:0] AWADDR_I,
  input wire logic AWVALID_I,
  output logic AWREADY_O,
  input wire logic [31:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  input wire logic WVALID_I,
  output logic WREADY_O,
  output logic [1:0] BRESP_O,
  output logic BVALID_O,
  input wire logic BREADY_I,
  input wire logic [7:0] ARADDR_I,
  input wire logic ARVALID_I,
  output logic ARREADY_O,
  output logic [31:0] RDATA_O,
  output logic [1:0] RRESP_O,
  output logic RVALID_O,
  input wire logic RREADY_I,
  input wire logic [2:0] LINE_I,
  output logic [2:0] LINE_O,
  output logic [2:0] LINE_OE_O,
  input wire logic EXPOSURE_I,
  output logic TRIGGER_O,
  input wire link_stat_t [NLINK-1:0] LINK_STAT_I,
  output lamp_t [NLINK-1:0] LAMP_O,
  output logic IRQ_O
);
  logic [5:0] in_func_q;
  logic [5:0] out_func_q;
  logic [2:0] pol_q;
  logic [2:0] dir_q;
  logic [2:0] usr_q;
  logic [31:0] delay_q;
  logic [31:0] width_q;
  logic [2:0] irq_st_q;
  logic [2:0] irq_en_q;
  logic [2:0] line_q, lvl_q;
  logic expo_q;
  logic [31:0] fe_cnt_q;
  logic fe_dly_q;
  logic fe_on_q;
  logic aw_q, w_q, ws_q;
  logic [7:0] awa_q;
  logic [31:0] wd_q;
  logic wr_go;
  logic [2:0] trig_hit;
  logic fe_start;
  // ****************
  // Register bus
  // ****************
  assign AWREADY_O = !aw_q && !BVALID_O;
  assign WREADY_O = !w_q && !BVALID_O;
  assign ARREADY_O = !RVALID_O;
  assign wr_go = aw_q && w_q && !BVALID_O;
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awa_q <= 8'h00;
      wd_q <= 32'h0000_0000;
      ws_q <= 1'b0;
      BVALID_O <= 1'b0;
      BRESP_O <= 2'h0;
    end else begin
      if (AWVALID_I && AWREADY_O) begin
        aw_q <= 1'b1;
        awa_q <= AWADDR_I;
      end
      if (WVALID_I && WREADY_O) begin
        w_q <= 1'b1;
        wd_q <= WDATA_I;
        ws_q <= WSTRB_I[0];
      end
      if (wr_go) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        BVALID_O <= 1'b1;
        BRESP_O <= known(awa_q) ? 2'h0 : 2'h2;
      end else if (BVALID_O && BREADY_I) begin
        BVALID_O <= 1'b0;
      end
    end
  end
  function automatic logic known(input logic [7:0] a);
    known = (a <= `OFS_DIR) && (a[1:0] == 2'h0);
  endfunction
  // Strobe 0, taken with the data, qualifies a write; no partial words
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      in_func_q <= 6'h00;
      out_func_q <= 6'h00;
      dir_q <= 3'h0;
      pol_q <= 3'h0;
      usr_q <= 3'h0;
      delay_q <= 32'h0000_0000;
      width_q <= `RST_WIDTH;
      irq_en_q <= 3'h0;
    end else if (wr_go && ws_q) begin
      if (awa_q == `OFS_IN_FUNC) begin
        in_func_q <= wd_q[5:0];
      end else if (awa_q == `OFS_OUT_FUNC) begin
        out_func_q <= wd_q[5:0];
      end else if (awa_q == `OFS_POL) begin
        pol_q <= wd_q[2:0];
      end else if (awa_q == `OFS_USR_OUT) begin
        usr_q <= wd_q[2:0];
      end else if (awa_q == `OFS_DELAY) begin
        delay_q <= wd_q;
      end else if (awa_q == `OFS_WIDTH) begin
        width_q <= wd_q;
      end else if (awa_q == `OFS_IRQ_EN) begin
        irq_en_q <= wd_q[2:0];
      end else if (awa_q == `OFS_DIR) begin
        dir_q <= wd_q[2:0];
      end
    end
  end
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      RVALID_O <= 1'b0;
      RDATA_O <= 32'h0000_0000;
      RRESP_O <= 2'h0;
    end else if (ARVALID_I && ARREADY_O) begin
      RVALID_O <= 1'b1;
      RRESP_O <= known(ARADDR_I) ? 2'h0 : 2'h2;
      if (ARADDR_I == `OFS_IN_FUNC) begin
        RDATA_O <= {26'h0, in_func_q};
      end else if (ARADDR_I == `OFS_OUT_FUNC) begin
        RDATA_O <= {26'h0, out_func_q};
      end else if (ARADDR_I == `OFS_POL) begin
        RDATA_O <= {29'h0, pol_q};
      end else if (ARADDR_I == `OFS_USR_OUT) begin
        RDATA_O <= {29'h0, usr_q};
      end else if (ARADDR_I == `OFS_DELAY) begin
        RDATA_O <= delay_q;
      end else if (ARADDR_I == `OFS_WIDTH) begin
        RDATA_O <= width_q;
      end else if (ARADDR_I == `OFS_LINE_STAT) begin
        RDATA_O <= {29'h0, line_q};
      end else if (ARADDR_I == `OFS_IRQ_STAT) begin
        RDATA_O <= {29'h0, irq_st_q};
      end else if (ARADDR_I == `OFS_IRQ_EN) begin
        RDATA_O <= {29'h0, irq_en_q};
      end else if (ARADDR_I == `OFS_DIR) begin
        RDATA_O <= {29'h0, dir_q};
      end else begin
        RDATA_O <= 32'h0000_0000;
      end
    end else if (RVALID_O && RREADY_I) begin
      RVALID_O <= 1'b0;
    end
  end
  // ****************
  // Line inputs
  // ****************
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      line_q <= 3'h0;
      lvl_q <= 3'h0;
    end else begin
      lvl_q <= LINE_I;
      for (int i = 0; i < 3; i++) begin
        // Disabled or output lines read back zero
        line_q[i] <= (!dir_q[i] && in_func_q[2*i+:2] != IN_OFF)
          ? LINE_I[i] : 1'b0;
      end
    end
  end
  // Raw level history, so enabling a line that sits high is no edge
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      trig_hit[i] = !dir_q[i] && in_func_q[2*i+:2] == IN_TRIG &&
        ((LINE_I[i] ^ pol_q[i]) && !(lvl_q[i] ^ pol_q[i]));
    end
  end
  // Trigger is one cycle later than the edge; edge preset only
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      TRIGGER_O <= 1'b0;
    end else begin
      TRIGGER_O <= |trig_hit;
    end
  end
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      irq_st_q <= 3'h0;
    end else begin
      // Set wins over a same-cycle clear
      irq_st_q <= (irq_st_q & ~((wr_go && ws_q && awa_q == `OFS_IRQ_CLR)
        ? wd_q[2:0] : 3'h0)) | trig_hit;
    end
  end
  assign IRQ_O = |(irq_st_q & irq_en_q);
  // ****************
  // Line outputs
  // ****************
  assign fe_start = expo_q && !EXPOSURE_I;
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      expo_q <= 1'b0;
      fe_dly_q <= 1'b0;
      fe_on_q <= 1'b0;
      fe_cnt_q <= 32'h0000_0000;
    end else begin
      expo_q <= EXPOSURE_I;
      if (fe_start) begin
        fe_dly_q <= (delay_q != 32'h0);
        fe_on_q <= (delay_q == 32'h0) && (width_q != 32'h0);
        fe_cnt_q <= (delay_q != 32'h0) ? delay_q : width_q;
      end else if (fe_cnt_q > 32'h1) begin
        fe_cnt_q <= fe_cnt_q - 32'h1;
      end else if (fe_dly_q) begin
        fe_dly_q <= 1'b0;
        fe_on_q <= (width_q != 32'h0);
        fe_cnt_q <= width_q;
      end else begin
        fe_on_q <= 1'b0;
        fe_cnt_q <= 32'h0000_0000;
      end
    end
  end
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      LINE_O <= 3'h0;
      LINE_OE_O <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        LINE_OE_O[i] <= dir_q[i] && out_func_q[2*i+:2] != OUT_OFF;
        case (out_func_q[2*i+:2])
          OUT_USER: LINE_O[i] <= usr_q[i];
          OUT_FEND: LINE_O[i] <= fe_on_q ^ pol_q[i];
          OUT_EXPO: LINE_O[i] <= EXPOSURE_I ^ pol_q[i];
          default: LINE_O[i] <= 1'b0;
        endcase
      end
    end
  end
  // ****************
  // Link lamps
  // ****************
  logic [31:0] slow_q, fast_q;
  logic slow_ph_q, fast_ph_q;
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      slow_q <= 32'h0;
      fast_q <= 32'h0;
      slow_ph_q <= 1'b0;
      fast_ph_q <= 1'b0;
    end else begin
      slow_q <= (slow_q == 32'(SLOW_CYC - 1)) ? 32'h0 : slow_q + 32'h1;
      fast_q <= (fast_q == 32'(FAST_CYC - 1)) ? 32'h0 : fast_q + 32'h1;
      if (slow_q == 32'(SLOW_CYC - 1)) slow_ph_q <= !slow_ph_q;
      if (fast_q == 32'(FAST_CYC - 1)) fast_ph_q <= !fast_ph_q;
    end
  end
  localparam lamp_t OFF = 2'b00, RED = 2'b10, GRN = 2'b01, ORG = 2'b11;
  for (genvar k = 0; k < NLINK; k++) begin : g_lamp
    link_stat_t s;
    logic [31:0] err_q, show_q;
    logic xe_q, pl_q;
    assign s = LINK_STAT_I[k];
    always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
        err_q <= 32'h0;
        show_q <= 32'h0;
        xe_q <= 1'b0;
        pl_q <= 1'b0;
      end else begin
        xe_q <= s.xfer_error;
        if (s.xfer_error && !xe_q) begin
          err_q <= 32'(ERR_CYC);
        end else if (err_q != 32'h0) begin
          err_q <= err_q - 32'h1;
        end
        pl_q <= s.linking && s.cable_power;
        // Minimum time counts from link start, not from each reload
        if (s.linking && s.cable_power && !pl_q) begin
          show_q <= 32'(MIN_SHOW_CYC);
        end else if (show_q != 32'h0) begin
          show_q <= show_q - 32'h1;
        end
      end
    end
    always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
        LAMP_O[k] <= OFF;
      end else if (s.sys_error) begin
        LAMP_O[k] <= fast_ph_q ? RED : OFF;
      end else if (XFER_ERR_FIRST && err_q != 32'h0) begin
        LAMP_O[k] <= RED;
      end else if (s.booting) begin
        LAMP_O[k] <= ORG;
      end else if (show_q != 32'h0 || (s.linking && s.cable_power)) begin
        LAMP_O[k] <= fast_ph_q ? GRN : ORG;
      end else if (s.linking) begin
        LAMP_O[k] <= fast_ph_q ? ORG : OFF;
      end else if (err_q != 32'h0) begin
        LAMP_O[k] <= RED;
      end else if (s.incompatible) begin
        LAMP_O[k] <= slow_ph_q ? RED : (s.cable_power ? GRN : ORG);
      end else if (s.connected && s.transferring) begin
        LAMP_O[k] <= fast_ph_q ? GRN : OFF;
      end else if (s.connected && s.wait_trig) begin
        LAMP_O[k] <= slow_ph_q ? ORG : OFF;
      end else if (s.connected) begin
        LAMP_O[k] <= GRN;
      end else if (s.ext_power) begin
        LAMP_O[k] <= slow_ph_q ? RED : OFF;
      end else begin
        LAMP_O[k] <= OFF;
      end
    end
  end
  // ****************
  // Checks
  // ****************
  AST_RESET_IN: assert property (@(posedge CLK_I) SRST_I |=>
    LINE_OE_O == 3'h0 && in_func_q == 6'h00) else $error("reset state");
  AST_OFF_IGN: assert property (@(posedge CLK_I) disable iff (SRST_I)
    in_func_q[1:0] == IN_OFF |=> !line_q[0]) else $error("off line read");
  AST_TRIG: assert property (@(posedge CLK_I) disable iff (SRST_I)
    trig_hit[0] |=> TRIGGER_O) else $error("trigger lost");
  AST_USER: assert property (@(posedge CLK_I) disable iff (SRST_I)
    out_func_q[1:0] == OUT_USER && $stable(out_func_q) |=>
    LINE_O[0] == $past(usr_q[0])) else $error("user out");
  AST_EXPO: assert property (@(posedge CLK_I) disable iff (SRST_I)
    out_func_q[1:0] == OUT_EXPO && $stable(out_func_q) |=>
    LINE_O[0] == ($past(EXPOSURE_I) ^ $past(pol_q[0]))) else $error("expo");
  AST_FE_NODLY: assert property (@(posedge CLK_I) disable iff (SRST_I)
    fe_start && delay_q == 32'h0 && width_q != 32'h0 |=> fe_on_q)
    else $error("frame end start");
  AST_IRQ: assert property (@(posedge CLK_I) disable iff (SRST_I)
    trig_hit[0] |=> irq_st_q[0]) else $error("irq not set");
  AST_SYSERR: assert property (@(posedge CLK_I) disable iff (SRST_I)
    LINK_STAT_I[0].sys_error |=> LAMP_O[0].green == 1'b0)
    else $error("sys error lamp");
  COV_TRIG: cover property (@(posedge CLK_I) TRIGGER_O);
  COV_FE: cover property (@(posedge CLK_I) fe_on_q);
  COV_WR: cover property (@(posedge CLK_I) wr_go);
endmodule
`default_nettype wire

// File: testbench/line_wiring.sv
`timescale 1ns/1ns
`default_nettype none
// ****
// External wiring of the three lines
// ****
module line_wiring (
  input wire logic clk_i,
  input wire logic [2:0] dev_i,
  input wire logic [2:0] dev_oe_i,
  input wire logic [2:0] ext_i,
  input wire logic [2:0] ext_oe_i,
  output logic [2:0] line_o
);
  // An undriven line wanders, so a stale level never passes for data
  logic [2:0] float_q = 3'h5;
  always_ff @(posedge clk_i) begin
    float_q <= ~float_q;
  end
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      if (dev_oe_i[k]) begin
        line_o[k] = dev_i[k];
      end else if (ext_oe_i[k]) begin
        line_o[k] = ext_i[k];
      end else begin
        line_o[k] = float_q[k];
      end
    end
  end
endmodule
`default_nettype wire

// File: testbench/camera_io_line_and_link_led_control_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "io_led_regs.svh"
module camera_io_line_and_link_led_control_bench import io_led_pkg::*; ;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] aw = 8'h00;
  logic [7:0] ar = 8'h00;
  logic [31:0] wd = 32'h0;
  logic awv = 1'b0;
  logic wv = 1'b0;
  logic bry = 1'b0;
  logic arv = 1'b0;
  logic rry = 1'b0;
  logic [2:0] ext = 3'h0;
  logic [2:0] eoe = 3'h0;
  logic [3:0] strb = 4'hF;
  logic expo = 1'b0;
  link_stat_t [1:0] stat = '0;
  logic awr, wr_o, bv, arr, rv, tr, irq;
  logic [1:0] br, rr;
  logic [31:0] rd_o, rdv;
  logic [1:0] rsp, wrsp;
  logic [2:0] lo, loe, li, v;
  lamp_t [1:0] lamp;
  int bad_count = 0;
  int samples_checked = 0;
  int seed = 40;
  int i, j, trg, d, w, first, hi2, lo1;

  always #50 clk = ~clk;

  line_wiring wires (.clk_i(clk), .dev_i(lo), .dev_oe_i(loe), .ext_i(ext),
    .ext_oe_i(eoe), .line_o(li));

  // Short counts keep blink and error windows inside a brief run
  io_led_ctrl #(.NLINK(2), .SLOW_CYC(4), .FAST_CYC(2), .MIN_SHOW_CYC(8),
    .ERR_CYC(40)) dut (.CLK_I(clk), .SRST_I(srst),
    .AWADDR_I(aw), .AWVALID_I(awv), .AWREADY_O(awr), .WDATA_I(wd),
    .WSTRB_I(strb), .WVALID_I(wv), .WREADY_O(wr_o), .BRESP_O(br),
    .BVALID_O(bv), .BREADY_I(bry), .ARADDR_I(ar), .ARVALID_I(arv),
    .ARREADY_O(arr), .RDATA_O(rd_o), .RRESP_O(rr), .RVALID_O(rv),
    .RREADY_I(rry), .LINE_I(li), .LINE_O(lo), .LINE_OE_O(loe),
    .EXPOSURE_I(expo), .TRIGGER_O(tr), .LINK_STAT_I(stat), .LAMP_O(lamp),
    .IRQ_O(irq));

  // ****
  // Bus and compare tasks
  // ****
  task test_done;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task hang;
    bad_count++;
    $display("ERROR bus_wait expected answer seen timeout");
    test_done();
  endtask

  task wr(input logic [7:0] a, input logic [31:0] dat);
    bit ok;
    ok = 0;
    @(posedge clk);
    aw <= a;
    wd <= dat;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    for (int n = 0; n < 50 && !ok; n++) begin
      @(posedge clk);
      if (awr === 1'b1) awv <= 1'b0;
      if (wr_o === 1'b1) wv <= 1'b0;
      if (bv === 1'b1) begin
        ok = 1;
        wrsp = br;
      end
    end
    bry <= 1'b0;
    if (!ok) hang();
  endtask

  task rd(input logic [7:0] a);
    bit ok;
    ok = 0;
    @(posedge clk);
    ar <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    for (int n = 0; n < 50 && !ok; n++) begin
      @(posedge clk);
      if (arr === 1'b1) arv <= 1'b0;
      if (rv === 1'b1) begin
        ok = 1;
        rdv = rd_o;
        rsp = rr;
      end
    end
    rry <= 1'b0;
    if (!ok) hang();
  endtask

  task edge_trig(input logic lv, input int e);
    int c;
    c = 0;
    @(posedge clk);
    ext[0] <= lv;
    repeat (8) begin
      @(posedge clk);
      c += (tr === 1'b1);
    end
    cmp("trigger", e, c);
  endtask

  // Mode 0 off, 1 solid, 2 blinking over an eight cycle window
  function automatic logic [1:0] mode(input int c);
    return (c == 0) ? 2'h0 : (c == 8) ? 2'h1 : 2'h2;
  endfunction

  task lamp_chk(input logic [9:0] s, input logic [3:0] e);
    int cr, cg;
    @(posedge clk);
    stat <= {s, s};
    repeat (3) @(posedge clk);
    for (int k = 0; k < 2; k++) begin
      cr = 0;
      cg = 0;
      repeat (8) begin
        @(posedge clk);
        cr += (lamp[k].red === 1'b1);
        cg += (lamp[k].green === 1'b1);
      end
      cmp("lamp", e, {mode(cr), mode(cg)});
    end
  endtask

  // ****
  // Main sequence
  // ****
  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    cmp("line_oe", 32'h0, loe);
    rd(`OFS_IN_FUNC);
    cmp("in_func", 32'h0, rdv);
    rd(`OFS_DIR);
    cmp("dir", 32'h0, rdv);
    // Strobe 0 low: this width write must not land
    strb <= 4'h0;
    wr(`OFS_WIDTH, 32'h55);
    strb <= 4'hF;
    rd(`OFS_WIDTH);
    cmp("width", `RST_WIDTH, rdv);
    rd(8'hFC);
    cmp("resp", 32'h2, rsp);
    wr(8'hFC, 32'h0);
    cmp("bresp", 32'h2, wrsp);
    $display("test reset done");
    eoe <= 3'h7;
    trg = 0;
    for (i = 0; i < 12; i++) begin
      @(posedge clk);
      ext <= 3'($random(seed));
      trg += (tr === 1'b1);
    end
    cmp("trig_off", 32'h0, trg);
    rd(`OFS_IRQ_STAT);
    cmp("irq_off", 32'h0, rdv);
    rd(`OFS_LINE_STAT);
    cmp("stat_off", 32'h0, rdv);
    wr(`OFS_IN_FUNC, 32'h15);
    for (i = 0; i < 4; i++) begin
      v = 3'($random(seed));
      @(posedge clk);
      ext <= v;
      repeat (3) @(posedge clk);
      rd(`OFS_LINE_STAT);
      cmp("level", v, rdv[2:0]);
    end
    $display("test input done");
    @(posedge clk);
    ext <= 3'h0;
    wr(`OFS_IN_FUNC, 32'h2);
    wr(`OFS_IRQ_EN, 32'h1);
    edge_trig(1'b1, 1);
    cmp("irq", 32'h1, irq);
    wr(`OFS_IRQ_CLR, 32'h7);
    repeat (2) @(posedge clk);
    cmp("irq_clr", 32'h0, irq);
    wr(`OFS_POL, 32'h1);
    edge_trig(1'b0, 1);
    edge_trig(1'b1, 0);
    $display("test trigger done");
    wr(`OFS_DIR, 32'h7);
    wr(`OFS_OUT_FUNC, 32'h15);
    for (i = 0; i < 4; i++) begin
      v = 3'($random(seed));
      wr(`OFS_USR_OUT, {29'h0, v});
      repeat (2) @(posedge clk);
      cmp("user_out", v, lo);
      cmp("line_oe", 32'h7, loe);
    end
    for (j = 0; j < 2; j++) begin
      // First pass is the zero-delay corner, then a random delay
      d = (j == 0) ? 0 : $unsigned($random(seed)) % 6;
      w = 1 + $unsigned($random(seed)) % 8;
      wr(`OFS_DELAY, d);
      wr(`OFS_WIDTH, w);
      wr(`OFS_POL, 32'h2);
      wr(`OFS_OUT_FUNC, 32'h2D);
      @(posedge clk);
      expo <= 1'b1;
      lo1 = 0;
      hi2 = 0;
      first = -1;
      for (i = 0; i < 60; i++) begin
        @(posedge clk);
        if (i == 5) expo <= 1'b0;
        lo1 += (lo[1] === 1'b0);
        if (lo[2] === 1'b1) begin
          if (first < 0) first = i;
          hi2++;
        end
      end
      cmp("expo_len", 32'h6, lo1);
      cmp("fend_len", w, hi2);
      cmp("fend_delay", 32'h1, first >= 6 + d && first <= 9 + d);
    end
    $display("test output done");
    srst <= 1'b1;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    cmp("line_oe_rst", 32'h0, loe);
    rd(`OFS_OUT_FUNC);
    cmp("out_func_rst", 32'h0, rdv);
    $display("test second reset done");
    lamp_chk(10'h000, 4'h0);
    lamp_chk(10'h200, 4'h5);
    lamp_chk(10'h100, 4'h8);
    lamp_chk(10'h0C0, 4'h9);
    lamp_chk(10'h140, 4'hA);
    // A one-cycle cable link must still show its pattern for a while
    @(posedge clk);
    stat <= {2{10'h0C0}};
    @(posedge clk);
    stat <= {2{10'h020}};
    trg = 0;
    repeat (6) begin
      @(posedge clk);
      trg += (lamp[0].red === 1'b1);
    end
    cmp("show_min", 32'h1, trg > 0);
    lamp_chk(10'h020, 4'h1);
    lamp_chk(10'h0B0, 4'hA);
    lamp_chk(10'h130, 4'h6);
    lamp_chk(10'h028, 4'hA);
    lamp_chk(10'h024, 4'h2);
    lamp_chk(10'h022, 4'h4);
    // Red ends once the error time has run out
    repeat (24) @(posedge clk);
    lamp_chk(10'h022, 4'h1);
    lamp_chk(10'h001, 4'h8);
    $display("test lamp done");
    test_done();
  end
endmodule
`default_nettype wire
